// *** rtl/gdio_map.svh ***
/*
  Address map, field positions and reset values of the general digital I/O port.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef GDIO_MAP_SVH
`define GDIO_MAP_SVH

// ------------------------------------------------------------
// Local address decode
// ------------------------------------------------------------
`define GDIO_AW 9
`define GDIO_PORT_LSB 5
`define GDIO_PORT_MSB 7
`define GDIO_REG_MSB 4
`define GDIO_HI_LSB 9

// ------------------------------------------------------------
// Per-port register offsets inside one 32-byte slot
// ------------------------------------------------------------
`define GDIO_OFF_PIN_SAMPLE 5'h00
`define GDIO_OFF_DIRECTION 5'h04
`define GDIO_OFF_LATCH 5'h08
`define GDIO_OFF_DIR_SET 5'h0C
`define GDIO_OFF_DIR_CLR 5'h10
`define GDIO_OFF_LATCH_SET 5'h14
`define GDIO_OFF_LATCH_CLR 5'h18

// ------------------------------------------------------------
// Global control register
// ------------------------------------------------------------
`define GDIO_OFF_MCU_CONTROL 9'h100
`define GDIO_PUD_BIT 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define GDIO_RST_MCU_CONTROL 1'b0
`define GDIO_RST_DIRECTION 1'b0
`define GDIO_RST_LATCH 1'b0
`define GDIO_RST_WORD 32'h0000_0000

// ------------------------------------------------------------
// Bus encodings
// ------------------------------------------------------------
`define GDIO_HTRANS_NONSEQ 2'h2
`define GDIO_HTRANS_SEQ 2'h3
`define GDIO_HRESP_OKAY 1'b0

`endif

// *** rtl/gdio_pkg.sv ***
/*
  Types shared by the general digital I/O port design.
  Assumes gdio_map.svh is on the include path.
*/
`include "gdio_map.svh"

package gdio_pkg;

  // Captured address phase, carried into the data phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`GDIO_AW-1:0] addr;
  } gdio_dphase_t;

endpackage

// *** rtl/gdio_port.sv ***
/*
  General digital I/O port block: NUM_PORTS ports of PORT_WIDTH pins each,
  three registers per port plus set/clear aliases, a global pull-up disable,
  reached as a zero-wait-state AHB-Lite slave.
  Each port owns a 32-byte slot: pin sample, direction and output latch words,
  then direction set/clear and latch set/clear aliases that read as zero.
  Writing ones to the pin sample word toggles latch bits, whatever the direction.
  The control word above the port slots holds only the pull-up disable bit.
  Pads change one register stage after the register they follow and the pin sample adds
  another, so software must allow two idle cycles before reading back a value it has just driven.
  Limitation: the alternate override inputs are plain per-pin selects, with no
  sleep clamping and no interrupt logic.
  Assumes a single AHB-Lite master, word transfers only, and pad cells that
  turn pad_oe/pad_out/pad_pullup into the actual pin level.
*/
// Chosen here: the address map and register access over AHB-Lite.
// Behaviour
// - Each port has an output latch, a direction register and a pin input register.
// - Pin input location is read-only; latch and direction are read/write.
// - Writing one to a pin input bit inverts that latch bit; zero does nothing.
// - Setting bit 4 of the MCU control register disables every pull-up.
// - Direction bit one makes the pin an output, zero an input.
// - Input pin pull-up is on only while its latch bit is one.
// - Reset tri-states all pins at once, with no clock needed.
// - Output pin drives high for latch one and low for latch zero.
// - Single-bit set/clear changes only the addressed bit; here the set/clear aliases change every bit written as one.
// - Alternate function on some pins leaves the other pins as plain I/O.
// - Pin input passes a high-transparent latch then a rising-edge register.
`timescale 1ns/1ns
`include "gdio_map.svh"

module gdio_port #(
  parameter int NUM_PORTS = 2,
  parameter int PORT_WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_in,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_en,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_oe,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_out,
  output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_out,
  output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_oe,
  output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_pullup
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // Per-pin configuration, one bit per pin of each port
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] direction_r;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] direction_nxt;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] latch_r;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] latch_nxt;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] sample_w;
  logic pullup_disable_r;
  logic pullup_disable_nxt;
  gdio_pkg::gdio_dphase_t dphase_r;
  gdio_pkg::gdio_dphase_t dphase_nxt;
  logic [31:0] rdata_nxt;
  logic in_window;

  // ------------------------------------------------------------
  // Pin input synchroniser, one instance per port
  // ------------------------------------------------------------
  // One synchroniser per port, so each port stays a self-contained slice
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_sync
    gdio_sync #(
      .WIDTH(PORT_WIDTH)
    ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .hce(hce),
      .din(pad_in[g]),
      .dout(sample_w[g])
    );
  end

  // ------------------------------------------------------------
  // AHB-Lite address phase capture
  // ------------------------------------------------------------

  // Anything above the local window is unmapped
  assign in_window = (haddr[31:`GDIO_HI_LSB] == '0);

  // Only NONSEQ/SEQ with hready high start a transfer
  always_comb begin
    dphase_nxt.wr = 1'b0;
    dphase_nxt.rd = 1'b0;
    dphase_nxt.addr = haddr[`GDIO_AW-1:0];
    if (hsel && hready && (htrans == `GDIO_HTRANS_NONSEQ || htrans == `GDIO_HTRANS_SEQ)) begin
      dphase_nxt.wr = hwrite;
      dphase_nxt.rd = !hwrite;
    end
    // Anything above the local window is unmapped: no write effect
    if (!in_window) begin
      dphase_nxt.wr = 1'b0;
    end
  end

  // Address phase held over into its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_r <= '0;
    end else if (hce) begin
      dphase_r <= dphase_nxt;
    end
  end

  // ------------------------------------------------------------
  // Register write decode (data phase)
  // ------------------------------------------------------------

  // Word writes act per bit so untouched pins keep their state
  always_comb begin
    direction_nxt = direction_r;
    latch_nxt = latch_r;
    pullup_disable_nxt = pullup_disable_r;
    if (dphase_r.wr) begin
      if (dphase_r.addr == `GDIO_OFF_MCU_CONTROL) begin
        pullup_disable_nxt = hwdata[`GDIO_PUD_BIT];
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (dphase_r.addr[`GDIO_AW-1:`GDIO_PORT_LSB] == (`GDIO_AW-`GDIO_PORT_LSB)'(p)) begin
          case (dphase_r.addr[`GDIO_REG_MSB:0])
            `GDIO_OFF_PIN_SAMPLE: begin
              latch_nxt[p] = latch_r[p] ^ hwdata[PORT_WIDTH-1:0];
            end
            `GDIO_OFF_DIRECTION: begin
              direction_nxt[p] = hwdata[PORT_WIDTH-1:0];
            end
            `GDIO_OFF_LATCH: begin
              latch_nxt[p] = hwdata[PORT_WIDTH-1:0];
            end
            `GDIO_OFF_DIR_SET: begin
              direction_nxt[p] = direction_r[p] | hwdata[PORT_WIDTH-1:0];
            end
            `GDIO_OFF_DIR_CLR: begin
              direction_nxt[p] = direction_r[p] & ~hwdata[PORT_WIDTH-1:0];
            end
            `GDIO_OFF_LATCH_SET: begin
              latch_nxt[p] = latch_r[p] | hwdata[PORT_WIDTH-1:0];
            end
            `GDIO_OFF_LATCH_CLR: begin
              latch_nxt[p] = latch_r[p] & ~hwdata[PORT_WIDTH-1:0];
            end
            default: begin
              latch_nxt[p] = latch_r[p];
            end
          endcase
        end
      end
    end
  end

  // Direction registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direction_r <= {NUM_PORTS*PORT_WIDTH{`GDIO_RST_DIRECTION}};
    end else if (hce) begin
      direction_r <= direction_nxt;
    end
  end

  // Output latches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_r <= {NUM_PORTS*PORT_WIDTH{`GDIO_RST_LATCH}};
    end else if (hce) begin
      latch_r <= latch_nxt;
    end
  end

  // Global pull-up disable; other control bits read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_disable_r <= `GDIO_RST_MCU_CONTROL;
    end else if (hce) begin
      pullup_disable_r <= pullup_disable_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read mux (address phase, registered into the data phase)
  // ------------------------------------------------------------

  // Reads use next values so a read right after a write sees the write
  always_comb begin
    rdata_nxt = `GDIO_RST_WORD;
    if (dphase_nxt.rd && in_window) begin
      if (dphase_nxt.addr == `GDIO_OFF_MCU_CONTROL) begin
        rdata_nxt[`GDIO_PUD_BIT] = pullup_disable_nxt;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (dphase_nxt.addr[`GDIO_AW-1:`GDIO_PORT_LSB] == (`GDIO_AW-`GDIO_PORT_LSB)'(p)) begin
          case (dphase_nxt.addr[`GDIO_REG_MSB:0])
            `GDIO_OFF_PIN_SAMPLE: begin
              rdata_nxt[PORT_WIDTH-1:0] = sample_w[p];
            end
            `GDIO_OFF_DIRECTION: begin
              rdata_nxt[PORT_WIDTH-1:0] = direction_nxt[p];
            end
            `GDIO_OFF_LATCH: begin
              rdata_nxt[PORT_WIDTH-1:0] = latch_nxt[p];
            end
            default: begin
              rdata_nxt = `GDIO_RST_WORD; // Set/clear aliases read zero
            end
          endcase
        end
      end
    end
  end

  // Read data stands for the data phase only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `GDIO_RST_WORD;
    end else if (hce) begin
      hrdata <= rdata_nxt;
    end
  end

  // Never stretches a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (hce) begin
      hreadyout <= 1'b1;
    end
  end

  // Never errors: every address, mapped or not, answers OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `GDIO_HRESP_OKAY;
    end else if (hce) begin
      hresp <= `GDIO_HRESP_OKAY;
    end
  end

  // ------------------------------------------------------------
  // Pad drive
  // ------------------------------------------------------------

  // Next pad values, registered below so every pin output comes from a flop
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_oe_nxt;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_out_nxt;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_pullup_nxt;
  logic [PORT_WIDTH-1:0] pull_allow;

  // Per-pin select keeps plain pins plain next to alternate ones
  always_comb begin
    pull_allow = {PORT_WIDTH{~pullup_disable_r}};
    for (int p = 0; p < NUM_PORTS; p++) begin
      pad_oe_nxt[p] = (alt_en[p] & alt_oe[p]) | (~alt_en[p] & direction_r[p]);
      // Drive value follows the latch, whatever the direction
      pad_out_nxt[p] = (alt_en[p] & alt_out[p]) | (~alt_en[p] & latch_r[p]);
      // A driven pin never also pulls up, so the pad sees no fight
      pad_pullup_nxt[p] = ~alt_en[p] & ~direction_r[p] & latch_r[p] & pull_allow;
    end
  end

  // Async reset clears the enables with no clock edge needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_oe <= '0;
    end else if (hce) begin
      pad_oe <= pad_oe_nxt;
    end
  end

  // Drive value register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= '0;
    end else if (hce) begin
      pad_out <= pad_out_nxt;
    end
  end

  // Pull-up only on an input pin with its latch bit high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_pullup <= '0;
    end else if (hce) begin
      pad_pullup <= pad_pullup_nxt;
    end
  end

  // PORT_WIDTH defaults to eight, bit n maps to pin n throughout

endmodule

// *** rtl/gdio_sync.sv ***
/*
  Pin input synchroniser: latch open while the clock is high, then a register
  loaded at the following rising edge.
  Assumes pad inputs are level signals; clock enable freezes the register.
*/
`timescale 1ns/1ns
module gdio_sync #(
  parameter int WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] hold_lat;

  // Transparent while the clock is high, closed while it is low
  always_latch begin
    if (hclk) begin
      hold_lat = din;
    end
  end

  // Only the register reads the latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout <= '0;
    end else if (hce) begin
      dout <= hold_lat;
    end
  end

endmodule

// *** sim/gdio_checker.sv ***
/*
  Port-level checker for the general digital I/O port.
  Assumes port 0 writes are checked with alt_en[0] low and hce high.
*/
`timescale 1ns/1ns
`include "gdio_map.svh"
module gdio_checker #(
  parameter int NUM_PORTS = 2,
  parameter int PORT_WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] alt_en,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_out,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_oe,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_pullup
);
  // ----------------------------------------
  // Write data-phase tracker
  // ----------------------------------------
  logic wr_r;
  logic [8:0] adr_r;
  // High in the data phase of a mapped write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      adr_r <= 9'h000;
    end else begin
      wr_r <= hsel & hready & htrans[1] & hwrite & hce & (haddr[31:9] == '0);
      adr_r <= haddr[8:0];
    end
  end
  // Pads follow one register stage after the data phase
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RST_HIZ: assert property (disable iff (1'b0)
    !hresetn |-> pad_oe == '0 && pad_pullup == '0) else $error("pins not high-z in reset");
  AST_PULL_OUT: assert property ((pad_pullup & pad_oe) == '0)
    else $error("pull-up on a driven pin");
  AST_PUD: assert property (wr_r && adr_r == `GDIO_OFF_MCU_CONTROL && hwdata[4]
    |-> ##2 pad_pullup == '0) else $error("pull-up kept after disable");
  AST_DIR: assert property (wr_r && adr_r == {4'h0, `GDIO_OFF_DIRECTION} && alt_en[0] == '0
    |-> ##2 pad_oe[0] == $past(hwdata[7:0], 2)) else $error("oe differs from direction");
  AST_LATCH: assert property (wr_r && adr_r == {4'h0, `GDIO_OFF_LATCH} && alt_en[0] == '0
    |-> ##2 pad_out[0] == $past(hwdata[7:0], 2)) else $error("drive differs from latch");
  AST_TOGGLE: assert property (wr_r && adr_r == {4'h0, `GDIO_OFF_PIN_SAMPLE} && alt_en[0] == '0
    |-> ##2 pad_out[0] == ($past(pad_out[0], 2) ^ $past(hwdata[7:0], 2)))
    else $error("toggle wrong");
  AST_LSET: assert property (wr_r && adr_r == {4'h0, `GDIO_OFF_LATCH_SET} && alt_en[0] == '0
    |-> ##2 pad_out[0] == ($past(pad_out[0], 2) | $past(hwdata[7:0], 2)))
    else $error("bit set wrong");
  AST_LCLR: assert property (wr_r && adr_r == {4'h0, `GDIO_OFF_LATCH_CLR} && alt_en[0] == '0
    |-> ##2 pad_out[0] == ($past(pad_out[0], 2) & ~$past(hwdata[7:0], 2)))
    else $error("bit clear wrong");
endmodule

bind gdio_port gdio_checker #(.NUM_PORTS(NUM_PORTS), .PORT_WIDTH(PORT_WIDTH)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .alt_en(alt_en), .pad_out(pad_out),
  .pad_oe(pad_oe), .pad_pullup(pad_pullup));

// *** sim/gdio_pins.sv ***
/*
  External circuitry on the port pins: resolves pin levels.
  Assumes the bench never drives a pin the port drives.
*/
`timescale 1ns/1ns
module gdio_pins #(
  parameter int NUM_PORTS = 2,
  parameter int PORT_WIDTH = 8
) (
  input wire logic hclk,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_out,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_oe,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_pullup,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] ext_drv,
  input wire logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] ext_val,
  output logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pad_in
);
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] flt_r = '0;
  // Floating pins wander, so a missing pull-up is seen
  always_ff @(posedge hclk) begin
    flt_r <= ~flt_r;
  end
  // Driver wins, then external source, then pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
    | (~pad_oe & ~ext_drv & (pad_pullup | flt_r));
endmodule

// *** sim/tb_general_digital_io_port.sv ***
/*
  Self-checking bench for the general digital I/O port.
  Assumes the zero-wait AHB-Lite slave and pads one stage after writes.
*/
`timescale 1ns/1ns
module tb_general_digital_io_port;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hresp;
  logic [1:0][7:0] alt_en = '0, alt_oe = '0, alt_out = '0, ext_drv = '0, ext_val = '0;
  logic [1:0][7:0] pad_in, pad_out, pad_oe, pad_pullup;
  int n_fail = 0;
  int checked = 0;
  localparam logic [31:0] P1 = 32'h0000_0020;
  localparam logic [31:0] MCU = 32'h0000_0100;
  localparam logic [31:0] PIN = 32'h0000_0000;
  localparam logic [31:0] DIR = 32'h0000_0004;
  localparam logic [31:0] LAT = 32'h0000_0008;

  always #50 hclk = ~hclk;

  gdio_port #(.NUM_PORTS(2), .PORT_WIDTH(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pad_in(pad_in), .alt_en(alt_en),
    .alt_oe(alt_oe), .alt_out(alt_out), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup));
  gdio_pins #(.NUM_PORTS(2), .PORT_WIDTH(8)) u_pins (
    .hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_drv(ext_drv), .ext_val(ext_val), .pad_in(pad_in));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single transfer; waits on hready, never a fixed count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    bus(0, DIR, 0);
    chk(rd, 0);
    bus(0, P1 + LAT, 0);
    chk(rd, 0);
    bus(1, MCU, 32'hFF);
    bus(0, MCU, 0);
    chk(rd, 32'h10);
    bus(1, MCU, 0);
    bus(1, DIR, 32'hA5);
    bus(1, LAT, 32'h3C);
    bus(0, DIR, 0);
    chk(rd, 32'hA5);
    bus(1, 32'h1FC, 32'hFF);
    bus(0, 32'h1FC, 0);
    chk(rd, 0);
    chk(hresp, 0);
  endtask
  // Mixed pins: driven, externally driven, pulled up
  task automatic t_pins;
    @(posedge hclk);
    ext_drv[0] <= 8'h42;
    ext_val[0] <= 8'h40;
    tick(2);
    chk(pad_oe, 16'h00A5);
    chk(pad_out[0], 8'h3C);
    chk(pad_pullup, 16'h0018);
    bus(0, PIN, 0);
    chk(rd, 32'h7C);
    ext_drv[0] <= 8'h00;
    bus(1, PIN, 32'h0F);
    bus(0, LAT, 0);
    chk(rd, 32'h33);
    bus(0, DIR, 0);
    chk(rd, 32'hA5);
  endtask
  // Set/clear aliases touch only the bits written as one
  task automatic t_bits;
    bus(1, 32'h14, 32'h80);
    bus(1, 32'h18, 32'h03);
    bus(1, 32'h10, 32'h05);
    bus(1, 32'h0C, 32'h40);
    bus(0, LAT, 0);
    chk(rd, 32'hB0);
    bus(0, DIR, 0);
    chk(rd, 32'hE0);
    tick(1);
    chk(pad_pullup, 16'h0010);
    bus(1, MCU, 32'h10);
    tick(2);
    chk(pad_pullup, 0);
    bus(1, MCU, 0);
  endtask
  // Port 1 inputs through the synchroniser
  task automatic t_sync;
    @(posedge hclk);
    ext_drv[1] <= 8'h0F;
    bus(1, P1 + LAT, 32'hFF);
    tick(2);
    bus(0, P1 + PIN, 0);
    chk(rd, 32'hF0);
    ext_val[1] <= 8'h05;
    bus(0, P1 + PIN, 0);
    chk(rd, 32'hF5);
  endtask
  // Override on low nibble leaves high nibble plain
  task automatic t_alt;
    @(posedge hclk);
    alt_en[0] <= 8'h0F;
    alt_oe[0] <= 8'h0F;
    alt_out[0] <= 8'h05;
    tick(2);
    chk(pad_oe[0], 8'hEF);
    chk(pad_out[0], 8'hB5);
    @(posedge hclk);
    alt_en[0] <= 8'h00;
  endtask
  // Reset mid-run, checked before any clock edge
  task automatic t_reset;
    bus(1, DIR, 32'hFF);
    tick(3);
    #20 hresetn = 1'b0;
    #1 chk(pad_oe, 0);
    chk(pad_pullup, 0);
    chk(pad_out, 0);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, DIR, 0);
    chk(rd, 0);
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_pins();
    t_bits();
    t_sync();
    t_alt();
    t_reset();
    wrap_up();
  end
  // Whole run needs about 103 cycles
  initial begin
    #500_000;
    n_fail++;
    wrap_up();
  end
endmodule
